//--- common/cio_pkg.sv
// constants shared by the configurable i/o port block
// assumes one 125 mhz clock and an apb slave with 32-bit data
package cio_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int NUM_PINS = NUM_PORTS * PORT_W;
    localparam int FOUR_PORT = 3;
    localparam int NARROW_PORT = 4;
    localparam int NARROW_MISSING_PIN = 7;
    localparam int XTAL_PORT = 6;
    localparam int XTAL_PIN_COUNT = 2;
    localparam logic [7:0] NARROW_MASK = 8'h7f;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA_BASE = 8'h00;
    localparam logic [7:0] OFS_MODE_BASE = 8'h20;
    localparam logic [7:0] OFS_MODE_HIGH = 8'h3c;
    localparam logic [7:0] OFS_PUC_FIRST = 8'h40;
    localparam logic [7:0] OFS_PUC_SECOND = 8'h44;
    localparam logic [7:0] OFS_CLK_CFG = 8'h48;
    localparam logic [7:0] OFS_LEVEL_BASE = 8'h60;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] PUC_RST = 8'h00;
    localparam logic CLK_CFG_RST = 1'b0;

    // ------------------------------------------------------------
    // mode encodings, {low bit, high bit} for the four-mode port
    // ------------------------------------------------------------
    localparam logic [1:0] FOUR_QUASI = 2'b00;
    localparam logic [1:0] FOUR_PUSH = 2'b01;
    localparam logic [1:0] FOUR_INPUT = 2'b10;
    localparam logic [1:0] FOUR_OPEN = 2'b11;
    localparam logic TWO_OPEN = 1'b0;
    localparam logic TWO_PUSH = 1'b1;

    // first pull-up control bit of each port in {second, first}
    localparam int PUC_POS [NUM_PORTS] = '{0, 2, 4, 0, 6, 8, 10};
    localparam int NIBBLE_W = 4;

endpackage

//--- rtl/cio_pin_cell.sv
// drive control of one port pin
// assumes pin_in is synchronous to pclk; all outputs are registered
`timescale 1ns/1ps
`default_nettype none

module cio_pin_cell
    import cio_pkg::*;
#(
    parameter bit FOUR_MODE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic latch,
    input wire logic [1:0] mode_sel,
    input wire logic pu_en,
    input wire logic take_over,
    input wire logic pin_in,
    output logic pin_level,
    output logic pull_down,
    output logic strong_up,
    output logic weak_up,
    output logic very_weak_up,
    output logic onchip_up
);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic sync1_reg, latch_prev_reg;
    wire is_quasi = FOUR_MODE && (mode_sel == FOUR_QUASI);
    wire is_push = FOUR_MODE ? (mode_sel == FOUR_PUSH) : (mode_sel[0] == TWO_PUSH);
    wire is_input = FOUR_MODE && (mode_sel == FOUR_INPUT);
    wire is_open = FOUR_MODE ? (mode_sel == FOUR_OPEN) : (mode_sel[0] == TWO_OPEN);
    wire live = !take_over; // RQ15
    wire rising = latch && !latch_prev_reg;
    // input-only never pulls down; every other mode shares one pull-down
    wire pd_next = live && !is_input && !latch; // RQ8 RQ9 RQ10 RQ11 RQ12
    wire strong_next = live && ((is_push && latch) || (is_quasi && rising)); // RQ7 RQ9 RQ13
    // weak pull-up follows the synchronised level, so it drops three cycles after the pin goes low
    wire weak_next = live && is_quasi && latch && pin_level; // RQ6
    wire vweak_next = live && is_quasi && latch; // RQ5
    wire onchip_next = live && !FOUR_MODE && is_open && pu_en; // RQ12 RQ18

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b1;
            pin_level <= 1'b1;
            latch_prev_reg <= DATA_RST[0];
            pull_down <= 1'b0;
            strong_up <= 1'b0;
            weak_up <= FOUR_MODE; // RQ3
            very_weak_up <= FOUR_MODE; // RQ3
            onchip_up <= 1'b0; // RQ4
        end else begin
            sync1_reg <= pin_in; // RQ19
            pin_level <= sync1_reg; // RQ19
            latch_prev_reg <= latch;
            pull_down <= pd_next;
            strong_up <= strong_next;
            weak_up <= weak_next;
            very_weak_up <= vweak_next;
            onchip_up <= onchip_next;
        end
    end

endmodule

`default_nettype wire

//--- rtl/cio_port_top.sv
// configurable i/o ports behind an apb slave
// assumes a single pclk domain, pins synchronous to it, external pad cells
// that turn the drive controls into pin levels
//
// Summary of operation
// (RQ1) four-mode port: two bits per pin pick quasi, push-pull, input, open-drain
// (RQ2) other ports: one bit per pin, 0 open-drain, 1 push-pull
// (RQ3) four-mode pins reset to quasi mode with weak pull-up on
// (RQ4) two-mode pins reset to open-drain with latch high
// (RQ5) quasi: very weak pull-up on whenever latch is 1
// (RQ6) quasi: weak pull-up on only while latch and pin are both 1
// (RQ7) quasi: latch rising 0 to 1 gives one clock of strong pull-up
// (RQ8) quasi: latch 0 drives pin low strongly; pin still readable
// (RQ9) four-mode push-pull: strong pull-up on 1, pull-down on 0
// (RQ10) input-only: no pull-up, no pull-down
// (RQ11) four-mode open-drain: no pull-ups, pull-down while latch is 0
// (RQ12) two-mode open-drain: pull-down on 0, on-chip pull-up if enabled
// (RQ13) two-mode push-pull: strong pull-up on 1, pull-down on 0
// (RQ14) software makes a two-mode input with open-drain and latch 1
// (RQ15) crystal select takes port 6 pins 0 and 1 off general use
// (RQ16) eight pins on each port except port 4, which has seven
// (RQ17) each pin's mode is set on its own
// (RQ18) one pull-up enable bit per port nibble, open-drain only
// (RQ19) pin levels pass a two-flop synchroniser before any use
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cio_port_top
    import cio_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_pull_down,
    output logic [NUM_PINS-1:0] pin_strong_up,
    output logic [NUM_PINS-1:0] pin_weak_up,
    output logic [NUM_PINS-1:0] pin_very_weak_up,
    output logic [NUM_PINS-1:0] pin_onchip_up,
    output logic crystal_pins_taken
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] port_latch_reg [NUM_PORTS];
    logic [7:0] port_mode_reg [NUM_PORTS];
    logic [7:0] four_mode_port_mode_high_reg;
    logic [7:0] pullup_control_first_reg;
    logic [7:0] pullup_control_second_reg;
    logic crystal_select_reg;
    wire [NUM_PINS-1:0] pin_level;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire [5:0] word = paddr[7:2];
    wire [2:0] port_idx = word[2:0];
    wire port_ok = (port_idx < 3'(NUM_PORTS));
    wire hit_data = (word[5:3] == OFS_DATA_BASE[7:5]) && port_ok;
    wire hit_mode = (word[5:3] == OFS_MODE_BASE[7:5]) && port_ok;
    wire hit_mode_high = (word == OFS_MODE_HIGH[7:2]);
    wire hit_puc_first = (word == OFS_PUC_FIRST[7:2]);
    wire hit_puc_second = (word == OFS_PUC_SECOND[7:2]);
    wire hit_clk_cfg = (word == OFS_CLK_CFG[7:2]);
    wire hit_level = (word[5:3] == OFS_LEVEL_BASE[7:5]) && port_ok;
    wire mapped = hit_data || hit_mode || hit_mode_high || hit_puc_first
        || hit_puc_second || hit_clk_cfg || hit_level;
    wire upper_zero = (paddr[1:0] == 2'b00);
    wire addr_ok = mapped && upper_zero;

    // ------------------------------------------------------------
    // apb phases
    // ------------------------------------------------------------
    // the answer is prepared in the setup cycle, so every access
    // completes in its first access cycle with registered outputs
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready;
    wire wr_en = access_done && pwrite && addr_ok;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] latch_rd = port_latch_reg[port_idx];
    wire [7:0] mode_rd = port_mode_reg[port_idx];
    wire [7:0] level_rd = pin_level[port_idx*PORT_W +: PORT_W];
    wire [7:0] rd_byte =
        hit_data ? latch_rd :
        hit_mode ? mode_rd :
        hit_mode_high ? four_mode_port_mode_high_reg :
        hit_puc_first ? pullup_control_first_reg :
        hit_puc_second ? pullup_control_second_reg :
        hit_clk_cfg ? {7'h00, crystal_select_reg} :
        hit_level ? level_rd :
        8'h00;
    wire [31:0] rd_next = addr_ok ? {24'h000000, rd_byte} : 32'h00000000;

    // port 4 has no bit 7, it neither stores nor reads back
    wire [7:0] wr_mask = (port_idx == 3'(NARROW_PORT)) ? NARROW_MASK : 8'hff; // RQ16

    // ------------------------------------------------------------
    // apb answer registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= pwrite ? 32'h00000000 : rd_next;
        end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // per-port registers
    // ------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            // a constant, so the asynchronous reset loads only constants
            localparam logic [7:0] KEEP = (gp == NARROW_PORT) ? NARROW_MASK : 8'hff;
            wire sel = (port_idx == 3'(gp));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port_latch_reg[gp] <= DATA_RST & KEEP; // RQ3 RQ4
                end else if (wr_en && hit_data && sel) begin
                    port_latch_reg[gp] <= pwdata[7:0] & wr_mask;
                end
            end

            // the four-mode port keeps its low mode bits here too
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port_mode_reg[gp] <= MODE_RST; // RQ3 RQ4
                end else if (wr_en && hit_mode && sel) begin
                    port_mode_reg[gp] <= pwdata[7:0] & wr_mask; // RQ17
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // shared control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            four_mode_port_mode_high_reg <= MODE_RST; // RQ3
        end else if (wr_en && hit_mode_high) begin
            four_mode_port_mode_high_reg <= pwdata[7:0]; // RQ1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_control_first_reg <= PUC_RST;
        end else if (wr_en && hit_puc_first) begin
            pullup_control_first_reg <= pwdata[7:0]; // RQ18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_control_second_reg <= PUC_RST;
        end else if (wr_en && hit_puc_second) begin
            pullup_control_second_reg <= pwdata[7:0]; // RQ18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_select_reg <= CLK_CFG_RST;
            crystal_pins_taken <= CLK_CFG_RST;
        end else begin
            if (wr_en && hit_clk_cfg) begin
                crystal_select_reg <= pwdata[0];
            end
            crystal_pins_taken <= crystal_select_reg; // RQ15
        end
    end

    // ------------------------------------------------------------
    // pin cells
    // ------------------------------------------------------------
    wire [15:0] puc_all = {pullup_control_second_reg, pullup_control_first_reg};

    genvar gq, gb;
    generate
        for (gq = 0; gq < NUM_PORTS; gq++) begin : g_pins
            for (gb = 0; gb < PORT_W; gb++) begin : g_bit
                localparam int N = gq * PORT_W + gb;
                localparam bit FOUR = (gq == FOUR_PORT);
                localparam int PU_BIT = PUC_POS[gq] + gb / NIBBLE_W;
                if (gq == NARROW_PORT && gb == NARROW_MISSING_PIN) begin : g_absent
                    // no pad exists; all drive controls stay off
                    assign pin_level[N] = 1'b0; // RQ16
                    assign pin_pull_down[N] = 1'b0;
                    assign pin_strong_up[N] = 1'b0;
                    assign pin_weak_up[N] = 1'b0;
                    assign pin_very_weak_up[N] = 1'b0;
                    assign pin_onchip_up[N] = 1'b0;
                end else begin : g_cell
                    wire [1:0] mode_sel = FOUR ?
                        {port_mode_reg[gq][gb], four_mode_port_mode_high_reg[gb]} : // RQ1
                        {1'b0, port_mode_reg[gq][gb]}; // RQ2
                    wire take = (gq == XTAL_PORT) && (gb < XTAL_PIN_COUNT)
                        && crystal_select_reg; // RQ15
                    wire pu_en = FOUR ? 1'b0 : puc_all[PU_BIT]; // RQ18
                    wire level_raw;

                    cio_pin_cell #(
                        .FOUR_MODE(FOUR)
                    ) u_cell (
                        .pclk(pclk),
                        .presetn(presetn),
                        .latch(port_latch_reg[gq][gb]),
                        .mode_sel(mode_sel),
                        .pu_en(pu_en),
                        .take_over(take),
                        .pin_in(pin_in[N]),
                        .pin_level(level_raw),
                        .pull_down(pin_pull_down[N]),
                        .strong_up(pin_strong_up[N]),
                        .weak_up(pin_weak_up[N]),
                        .very_weak_up(pin_very_weak_up[N]),
                        .onchip_up(pin_onchip_up[N])
                    );

                    // crystal pins read as zero while the oscillator owns them
                    assign pin_level[N] = level_raw && !take; // RQ15 RQ8
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- testbench/cio_pin_partner.sv
// far side: circuits on the pins, each with a resistor to the supply
// assumes ext_low comes from the bench to pull chosen pins low
`timescale 1ns/1ps
`default_nettype none

module cio_pin_partner
    import cio_pkg::*;
(
    input wire logic [NUM_PINS-1:0] ext_low,
    input wire logic [NUM_PINS-1:0] pull_down,
    output logic [NUM_PINS-1:0] pin_in
);
    // a pull-down or an outside sink wins over every pull-up
    assign pin_in = ~ext_low & ~pull_down;
endmodule

`default_nettype wire

//--- testbench/cio_port_assertions.sv
// checker: relations among the pin drive outputs and the apb answer
// assumes it is bound into cio_port_top; pins indexed port*8+bit
`timescale 1ns/1ps
`default_nettype none

module cio_port_assertions
    import cio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_pull_down,
    input wire logic [NUM_PINS-1:0] pin_strong_up,
    input wire logic [NUM_PINS-1:0] pin_weak_up,
    input wire logic [NUM_PINS-1:0] pin_very_weak_up,
    input wire logic [NUM_PINS-1:0] pin_onchip_up,
    input wire logic crystal_pins_taken
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_drive_fight: assert property ((pin_strong_up & pin_pull_down) == '0)
        else $error("strong pull-up and pull-down on together");
    a_weak_needs_vw: assert property ((pin_weak_up & ~pin_very_weak_up) == '0)
        else $error("weak pull-up without very weak pull-up");
    a_quasi_port_only: assert property ({pin_weak_up[55:32], pin_weak_up[23:0],
        pin_very_weak_up[55:32], pin_very_weak_up[23:0]} == '0)
        else $error("quasi pull-up outside the four-mode port");
    a_onchip_od_only: assert property ((pin_onchip_up & pin_strong_up) == '0
        && pin_onchip_up[31:24] == '0)
        else $error("on-chip pull-up outside open-drain");
    a_narrow_pin: assert property ({pin_pull_down[39], pin_strong_up[39],
        pin_weak_up[39], pin_very_weak_up[39], pin_onchip_up[39]} == '0)
        else $error("missing port 4 pin drives");
    a_weak_drop: assert property (!pin_in[25] [*3] |=> !pin_weak_up[25])
        else $error("weak pull-up held against low pin");
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("apb ready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("apb error without ready");
    a_xtal_quiet: assert property (crystal_pins_taken && $past(crystal_pins_taken)
        |-> {pin_pull_down[49:48], pin_strong_up[49:48], pin_onchip_up[49:48]} == '0)
        else $error("crystal pins still driven");
endmodule

`default_nettype wire

//--- testbench/testbench.sv
// bench: apb master, pin partner and scenario tasks
// assumes the design answers apb with zero wait states
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import cio_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, crystal_pins_taken, rerr;
    logic [NUM_PINS-1:0] pin_in, pin_pull_down, pin_strong_up, pin_weak_up;
    logic [NUM_PINS-1:0] pin_very_weak_up, pin_onchip_up, ext_low = '0;
    int errors = 0, total_checks = 0;

    always #4 pclk = ~pclk;
    cio_port_top u_cio_port_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_pull_down, .pin_strong_up, .pin_weak_up,
        .pin_very_weak_up, .pin_onchip_up, .crystal_pins_taken);
    cio_pin_partner u_cio_pin_partner (.ext_low, .pull_down(pin_pull_down), .pin_in);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            $display("FAIL apb ready expected 1 seen %b", pready);
            errors++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] a [6] = '{8'h00, 8'h10, 8'h2c, 8'h3c, 8'h40, 8'h48};
        logic [7:0] e [6] = '{8'hff, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};
        chk("quasi ups", 16'hffff, {pin_weak_up[31:24], pin_very_weak_up[31:24]});
        chk("no drive", '0, pin_pull_down | pin_strong_up | pin_onchip_up);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset reg", {33'h0, e[i]}, {rerr, rdat});
        end
        $display("reset test done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(8'h2c, {7'h0, m[1]});
            wr(8'h3c, {7'h0, m[0]});
            wr(8'h0c, 8'hfe);
            cyc(3);
            chk("latch0", {63'h0, m != 2} << 3, {pin_pull_down[24],
                pin_strong_up[24], pin_very_weak_up[24], pin_onchip_up[24]});
            wr(8'h0c, 8'hff);
            cyc(3);
            chk("latch1", {62'h0, m == 1, m == 0} << 1, {pin_pull_down[24],
                pin_strong_up[24], pin_very_weak_up[24], pin_onchip_up[24]});
        end
        wr(8'h2c, 8'h00);
        wr(8'h3c, 8'h00);
        $display("mode test done");
    endtask
    task automatic t_quasi();
        wr(8'h0c, 8'hfe);
        cyc(3);
        wr(8'h0c, 8'hff);
        cyc(1);
        chk("strong on", 2'b10, {pin_strong_up[24], pin_pull_down[24]});
        cyc(1);
        chk("strong off", 2'b01, {pin_strong_up[24], pin_very_weak_up[24]});
        @(posedge pclk);
        ext_low[25] <= 1'b1;
        cyc(5);
        chk("weak off", 2'b01, {pin_weak_up[25], pin_very_weak_up[25]});
        apb(1'b0, 8'h6c, 32'h0);
        chk("quasi level", 64'hfd, rdat);
        ext_low[25] <= 1'b0;
        $display("quasi test done");
    endtask
    task automatic t_two();
        wr(8'h00, 8'hfd);
        wr(8'h40, 8'h01);
        cyc(3);
        chk("od", 16'h020f, {pin_pull_down[7:0], pin_onchip_up[7:0]});
        wr(8'h20, 8'h03);
        cyc(3);
        chk("pp", 24'h01020c, {pin_strong_up[7:0], pin_pull_down[7:0],
            pin_onchip_up[7:0]});
        wr(8'h20, 8'h00);
        wr(8'h00, 8'hff);
        wr(8'h40, 8'h00);
        ext_low[3] <= 1'b1;
        cyc(4);
        chk("input", '0, {pin_strong_up[7:0], pin_pull_down[7:0], pin_onchip_up[7:0]});
        apb(1'b0, 8'h60, 32'h0);
        chk("input level", 64'hf7, rdat);
        ext_low[3] <= 1'b0;
        $display("two-mode test done");
    endtask
    task automatic t_xtal_bus();
        wr(8'h38, 8'hff);
        wr(8'h48, 8'h01);
        cyc(4);
        chk("xtal drive", 8'hfc, pin_strong_up[55:48]);
        chk("xtal flag", 1'b1, crystal_pins_taken);
        apb(1'b0, 8'h78, 32'h0);
        chk("xtal level", 64'hfc, rdat);
        wr(8'h48, 8'h00);
        wr(8'h10, 8'hff);
        apb(1'b0, 8'h10, 32'h0);
        chk("port4 width", 64'h7f, {rerr, rdat});
        chk("xtal free", 1'b0, crystal_pins_taken);
        apb(1'b0, 8'h50, 32'h0);
        chk("unmapped", 64'h1_0000_0000, {rerr, rdat});
        wr(8'h0d, 8'h00);
        chk("misaligned", 1'b1, rerr);
        wr(8'h60, 8'h00);
        apb(1'b0, 8'h60, 32'h0);
        chk("level ro", 64'hff, {rerr, rdat});
        $display("crystal and bus test done");
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cyc(4);
        t_reset();
        t_modes();
        t_quasi();
        t_two();
        t_xtal_bus();
        close_out();
    end
endmodule

bind cio_port_top cio_port_assertions u_cio_port_assertions (.pclk, .presetn, .psel,
    .penable, .pready, .pslverr, .pin_in, .pin_pull_down, .pin_strong_up, .pin_weak_up,
    .pin_very_weak_up, .pin_onchip_up, .crystal_pins_taken);

`default_nettype wire
